// File: verilog/davc_defs.vh
`ifndef DAVC_DEFS_VH
`define DAVC_DEFS_VH

// ==========================================================================
// Register offsets
`define DAVC_ADDR_ERR_TALLY   8'h25
`define DAVC_ADDR_SCL_HIGH    8'h26
`define DAVC_ADDR_SCL_LOW     8'h27
`define DAVC_ADDR_AUDIO_PATH  8'h28
`define DAVC_ADDR_DITHER      8'h29
`define DAVC_ADDR_COLOR_TBL   8'h2a
`define DAVC_ADDR_AUDIO_PLL   8'h2b

// ==========================================================================
// Reset values
`define DAVC_RST_ERR_TALLY    8'h00
`define DAVC_RST_SCL_HIGH     8'h83
`define DAVC_RST_SCL_LOW      8'h84
`define DAVC_RST_AUDIO_PATH   8'h00
`define DAVC_RST_DITHER       8'h00
`define DAVC_RST_COLOR_TBL    8'h00
`define DAVC_RST_AUDIO_PLL    8'h00

// ==========================================================================
// Writable bit masks (reserved bits stay zero)
`define DAVC_MASK_AUDIO_PATH  8'h8d
`define DAVC_MASK_DITHER      8'hff
`define DAVC_MASK_COLOR_TBL   8'hf0
`define DAVC_MASK_AUDIO_PLL   8'hc1

// ==========================================================================
// Field positions
`define DAVC_AP_BLOCK_FC      7
`define DAVC_AP_AUX_EN        3
`define DAVC_AP_OUT_DIS       2
`define DAVC_AP_SURROUND      0
`define DAVC_DT_SYNC_MODE     7
`define DAVC_DT_HS_POL        6
`define DAVC_DT_VS_POL        5
`define DAVC_DT_DE_POL        4
`define DAVC_DT_STAGE_TWO     3
`define DAVC_DT_STAGE_ONE     2
`define DAVC_DT_HI_TWO_N      1
`define DAVC_DT_HI_ONE_N      0
`define DAVC_CT_PAGE_HI       7
`define DAVC_CT_PAGE_LO       6
`define DAVC_CT_WB_EN         5
`define DAVC_CT_RELOAD_EN     4
`define DAVC_PL_OVERRIDE      7
`define DAVC_PL_OFF           6
`define DAVC_PL_EDGE          0

// ==========================================================================
// Timing: SCL counts are in 50 ns units, clock is 10 ns
`define DAVC_UNIT_NS          50
`define DAVC_CLK_NS           10
`define DAVC_UNIT_CYC         (`DAVC_UNIT_NS / `DAVC_CLK_NS)
`define DAVC_UNIT_LAST        3'h4
`define DAVC_TALLY_MAX        8'hff

`endif

// File: verilog/davc_unit_tick.v
`timescale 1ns/1ps
`include "davc_defs.vh"

// ==========================================================================
// One-cycle enable every 50 ns time unit
module davc_unit_tick (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst_b,
  // Tick
  output reg  tick
);

  reg [2:0] cnt;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt  <= 3'h0;
      tick <= 1'b0;
    end else if (cnt == `DAVC_UNIT_LAST) begin
      cnt  <= 3'h0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 3'h1;
      tick <= 1'b0;
    end
  end

endmodule // davc_unit_tick

// File: verilog/davc_scl_timer.v
`timescale 1ns/1ps
`include "davc_defs.vh"

// ==========================================================================
// Loads a count in time units and reports when it has run out
module davc_scl_timer (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // Control
  input  wire       tick,
  input  wire       load,
  input  wire [7:0] count,
  // Status
  output wire       busy,
  output reg        done
);

  reg [7:0] left;

  assign busy = (left != 8'h00);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      left <= 8'h00;
      done <= 1'b0;
    end else if (load) begin
      // A zero count still lasts one unit so SCL never glitches
      left <= (count == 8'h00) ? 8'h01 : count;
      done <= 1'b0;
    end else if (tick && busy) begin
      left <= left - 8'h01;
      done <= (left == 8'h01);
    end else begin
      done <= 1'b0;
    end
  end

endmodule // davc_scl_timer

// File: verilog/davc_cfg_regs.v
`timescale 1ns/1ps
`include "davc_defs.vh"

// Overview of operation
// - Self-test errors counted in a read-only 8-bit tally saturating at 255
// - Tally cleared on power-down low and on every new self-test start
// - Local master holds SCL high for programmed 50 ns units, reset 0x83
// - Local master holds SCL low for programmed 50 ns units, reset 0x84
// - Slave drives SDA valid for the SCL low count before releasing SCL
// - Bit 7 of audio path register blocks forward-channel updates to it
// - Bit 3 puts auxiliary I2S word select on GPIO1 and data on GPIO0
// - Bit 2 disables the I2S outputs, not aux I2S on GPIO1/GPIO0; clear keeps them enabled
// - Bit 0 selects surround audio; clear keeps 2 or 4 channel mode
// - Surround only travels in data-island transport, never frame transport
// - A repeater may override surround with in-band audio mode detection
// - Dither register bit 7 picks sync timing, zero is data-enable timing
// - Bits 6, 5, 4 set HS, VS, DE polarity; one means active low
// - Bits 3 and 2 enable dither stages two and one; off at reset
// - Bits 1 and 0 disable high dither stages two and one when set
// - Page field 7:6 selects config, red, green or blue table
// - Bit 5 of color table register enables white balance
// - Bit 4 of color table register enables table reload
// - With PLL override set, bit 6 turns audio PLL off, else runs
// - Bit 0 picks strobe edge: zero falling, one rising
module davc_cfg_regs (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // Power-down pin, active low
  input  wire       powerdown_bar_pin,
  // Local register port from the control-bus slave
  input  wire       reg_wr,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Forward-channel load of the audio path register
  input  wire       fc_wr,
  input  wire [7:0] fc_wdata,
  // Self-test
  input  wire       selftest_run,
  input  wire       selftest_err,
  // Repeater surround detection
  input  wire       repeater_mode,
  input  wire       inband_surround_vld,
  input  wire       inband_surround,
  // Transport select from elsewhere, one is frame transport
  input  wire       frame_transport,
  // Local I2C master SCL generation
  input  wire       master_start,
  output reg        master_scl_out,
  output wire       master_busy,
  // Control-channel slave SDA setup
  input  wire       slave_data_ready,
  output reg        slave_scl_release,
  // Audio outputs
  output wire       aux_i2s_en,
  output wire       gpio1_is_aux_ws,
  output wire       gpio0_is_aux_data,
  output wire       i2s_out_en,
  output wire       surround_en,
  output wire       audio_pll_on,
  output wire       strobe_rising,
  // Video timing and dither
  output wire       sync_timing_mode,
  output wire       hs_active_low,
  output wire       vs_active_low,
  output wire       de_active_low,
  output wire       dither_stage_two,
  output wire       dither_stage_one,
  output wire       high_dither_stage_two,
  output wire       high_dither_stage_one,
  // White balance
  output wire [1:0] table_page,
  output wire       white_balance_en,
  output wire       table_reload_en
);

  // ==========================================================================
  // Registers
  reg [7:0] selftest_error_tally;
  reg [7:0] i2c_master_clk_high_period;
  reg [7:0] i2c_master_clk_low_period;
  reg [7:0] audio_path_ctrl_second;
  reg [7:0] dither_sync_ctrl;
  reg [7:0] color_table_ctrl;
  reg [7:0] audio_pll_edge_ctrl;
  reg       run_d;
  reg       surround_det;

  // Power-down low resets like rst_b, except reg_rdata and the SCL timer and tick divider
  wire clr_all  = !rst_b || !powerdown_bar_pin;
  wire run_rise = selftest_run && !run_d;

  // ==========================================================================
  // Self-test tally
  always @(posedge clk_sys) begin
    if (clr_all) begin
      run_d <= 1'b0;
    end else begin
      run_d <= selftest_run;
    end
  end

  // An error in the cycle a run starts is lost to the clear
  always @(posedge clk_sys) begin
    if (clr_all) begin
      selftest_error_tally <= `DAVC_RST_ERR_TALLY;
    end else if (run_rise) begin
      selftest_error_tally <= 8'h00;
    end else if (selftest_run && selftest_err &&
                 selftest_error_tally != `DAVC_TALLY_MAX) begin
      selftest_error_tally <= selftest_error_tally + 8'h01;
    end
  end

  // ==========================================================================
  // Writable registers; the power-down pin also returns them to defaults
  always @(posedge clk_sys) begin
    if (clr_all) begin
      i2c_master_clk_high_period <= `DAVC_RST_SCL_HIGH;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_SCL_HIGH) begin
      i2c_master_clk_high_period <= reg_wdata;
    end
  end

  always @(posedge clk_sys) begin
    if (clr_all) begin
      i2c_master_clk_low_period <= `DAVC_RST_SCL_LOW;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_SCL_LOW) begin
      i2c_master_clk_low_period <= reg_wdata;
    end
  end

  // Any local write in the same cycle suppresses a forward-channel load
  always @(posedge clk_sys) begin
    if (clr_all) begin
      audio_path_ctrl_second <= `DAVC_RST_AUDIO_PATH;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_AUDIO_PATH) begin
      audio_path_ctrl_second <= reg_wdata & `DAVC_MASK_AUDIO_PATH;
    end else if (fc_wr && !reg_wr && !audio_path_ctrl_second[`DAVC_AP_BLOCK_FC]) begin
      audio_path_ctrl_second <= fc_wdata & `DAVC_MASK_AUDIO_PATH;
    end
  end

  always @(posedge clk_sys) begin
    if (clr_all) begin
      dither_sync_ctrl <= `DAVC_RST_DITHER;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_DITHER) begin
      dither_sync_ctrl <= reg_wdata & `DAVC_MASK_DITHER;
    end
  end

  always @(posedge clk_sys) begin
    if (clr_all) begin
      color_table_ctrl <= `DAVC_RST_COLOR_TBL;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_COLOR_TBL) begin
      color_table_ctrl <= reg_wdata & `DAVC_MASK_COLOR_TBL;
    end
  end

  always @(posedge clk_sys) begin
    if (clr_all) begin
      audio_pll_edge_ctrl <= `DAVC_RST_AUDIO_PLL;
    end else if (reg_wr && reg_addr == `DAVC_ADDR_AUDIO_PLL) begin
      audio_pll_edge_ctrl <= reg_wdata & `DAVC_MASK_AUDIO_PLL;
    end
  end

  // ==========================================================================
  // Repeater in-band surround detection latch
  // Holds the last report so surround does not drop between reports
  always @(posedge clk_sys) begin
    if (clr_all) begin
      surround_det <= 1'b0;
    end else if (inband_surround_vld) begin
      surround_det <= inband_surround;
    end
  end

  // ==========================================================================
  // Read mux
  // Registered, so data trails the address by one cycle
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == `DAVC_ADDR_ERR_TALLY) begin
      reg_rdata <= selftest_error_tally;
    end else if (reg_addr == `DAVC_ADDR_SCL_HIGH) begin
      reg_rdata <= i2c_master_clk_high_period;
    end else if (reg_addr == `DAVC_ADDR_SCL_LOW) begin
      reg_rdata <= i2c_master_clk_low_period;
    end else if (reg_addr == `DAVC_ADDR_AUDIO_PATH) begin
      reg_rdata <= audio_path_ctrl_second;
    end else if (reg_addr == `DAVC_ADDR_DITHER) begin
      reg_rdata <= dither_sync_ctrl;
    end else if (reg_addr == `DAVC_ADDR_COLOR_TBL) begin
      reg_rdata <= color_table_ctrl;
    end else if (reg_addr == `DAVC_ADDR_AUDIO_PLL) begin
      reg_rdata <= audio_pll_edge_ctrl;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Audio controls
  // Both GPIO pins follow the one enable bit
  assign aux_i2s_en        = audio_path_ctrl_second[`DAVC_AP_AUX_EN];
  assign gpio1_is_aux_ws   = aux_i2s_en;
  assign gpio0_is_aux_data = aux_i2s_en;
  assign i2s_out_en        = !audio_path_ctrl_second[`DAVC_AP_OUT_DIS];
  // Frame transport cannot carry surround, so surround is forced off there
  reg        surround_sel;

  always @* begin
    if (frame_transport) begin
      surround_sel = 1'b0;
    end else if (repeater_mode) begin
      surround_sel = surround_det;
    end else begin
      surround_sel = audio_path_ctrl_second[`DAVC_AP_SURROUND];
    end
  end

  assign surround_en   = surround_sel;
  // The off bit counts only under the override
  assign audio_pll_on  = !(audio_pll_edge_ctrl[`DAVC_PL_OVERRIDE] &&
                           audio_pll_edge_ctrl[`DAVC_PL_OFF]);
  assign strobe_rising = audio_pll_edge_ctrl[`DAVC_PL_EDGE];

  // ==========================================================================
  // Video timing, dither and white balance
  // Reset leaves high dither on, as its bits are inverted
  assign sync_timing_mode      = dither_sync_ctrl[`DAVC_DT_SYNC_MODE];
  assign hs_active_low         = dither_sync_ctrl[`DAVC_DT_HS_POL];
  assign vs_active_low         = dither_sync_ctrl[`DAVC_DT_VS_POL];
  assign de_active_low         = dither_sync_ctrl[`DAVC_DT_DE_POL];
  assign dither_stage_two      = dither_sync_ctrl[`DAVC_DT_STAGE_TWO];
  assign dither_stage_one      = dither_sync_ctrl[`DAVC_DT_STAGE_ONE];
  assign high_dither_stage_two = !dither_sync_ctrl[`DAVC_DT_HI_TWO_N];
  assign high_dither_stage_one = !dither_sync_ctrl[`DAVC_DT_HI_ONE_N];
  assign table_page       = color_table_ctrl[`DAVC_CT_PAGE_HI:`DAVC_CT_PAGE_LO];
  assign white_balance_en = color_table_ctrl[`DAVC_CT_WB_EN];
  assign table_reload_en  = color_table_ctrl[`DAVC_CT_RELOAD_EN];

  // ==========================================================================
  // SCL timing shared by master and slave roles
  // One-hot; slave setup reuses the low-period count
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_LOW   = 4'b0010;
  localparam [3:0] ST_HIGH  = 4'b0100;
  localparam [3:0] ST_SETUP = 4'b1000;

  reg  [3:0] state;
  reg  [3:0] next_state;
  reg        tmr_load;
  reg  [7:0] tmr_count;
  wire       tick;
  wire       tmr_busy;
  wire       tmr_done;
  // Restart the divider on each load so every period is whole units
  wire       tick_rst_b = rst_b && !tmr_load;

  davc_unit_tick u_tick (
    .clk_sys (clk_sys),
    .rst_b   (tick_rst_b),
    .tick    (tick)
  );

  davc_scl_timer u_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (tick),
    .load    (tmr_load),
    .count   (tmr_count),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // Busy spans both halves of the master period
  assign master_busy = (state == ST_LOW) || (state == ST_HIGH);

  always @* begin
    next_state = state;
    tmr_load   = 1'b0;
    tmr_count  = i2c_master_clk_low_period;
    case (state)
      ST_IDLE: begin
        // A slave setup wins over a master start
        if (slave_data_ready) begin
          next_state = ST_SETUP;
          tmr_load   = 1'b1;
        end else if (master_start) begin
          next_state = ST_LOW;
          tmr_load   = 1'b1;
        end
      end
      ST_LOW: begin
        if (tmr_done) begin
          next_state = ST_HIGH;
          tmr_load   = 1'b1;
          tmr_count  = i2c_master_clk_high_period;
        end
      end
      ST_HIGH: begin
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (clr_all) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // SCL comes from the next state so it never glitches between states
  always @(posedge clk_sys) begin
    if (clr_all) begin
      master_scl_out    <= 1'b1;
      slave_scl_release <= 1'b0;
    end else begin
      master_scl_out    <= (next_state != ST_LOW);
      slave_scl_release <= (state == ST_SETUP) && tmr_done;
    end
  end

endmodule // davc_cfg_regs

// File: tb/davc_chk.sv
`timescale 1ns/1ps
// ==========
// Port-level checks of the configuration block
module davc_chk (
  // Clock, reset and power-down
  input wire       clk_sys, rst_b, powerdown_bar_pin,
  // Register port
  input wire       reg_wr,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  // Timer handshakes
  input wire       frame_transport, master_start, slave_data_ready,
  input wire       master_scl_out, master_busy, slave_scl_release,
  // Decoded controls
  input wire       surround_en, aux_i2s_en, gpio1_is_aux_ws, i2s_out_en, audio_pll_on,
  input wire       strobe_rising, sync_timing_mode, hs_active_low, vs_active_low,
  input wire       de_active_low, dither_stage_two, dither_stage_one,
  input wire       high_dither_stage_two, high_dither_stage_one, white_balance_en,
  input wire       table_reload_en,
  input wire [1:0] table_page
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Write data of the previous cycle, so decodes can be tied to it
  reg  [7:0] wd_q;
  wire       wr_ok = reg_wr && powerdown_bar_pin;
  always @(posedge clk_sys) begin
    wd_q <= reg_wdata;
  end
  // ==========
  // Assertions
  dither_decode_a: assert property (wr_ok && reg_addr == 8'h29 |=>
    {sync_timing_mode, hs_active_low, vs_active_low, de_active_low, dither_stage_two,
     dither_stage_one, high_dither_stage_two, high_dither_stage_one} == {wd_q[7:2], ~wd_q[1:0]})
    else $error("dither controls do not follow the written value");
  table_decode_a: assert property (wr_ok && reg_addr == 8'h2a |=>
    {table_page, white_balance_en, table_reload_en} == wd_q[7:4])
    else $error("table controls do not follow the written value");
  pll_decode_a: assert property (wr_ok && reg_addr == 8'h2b |=>
    audio_pll_on == !(wd_q[7] && wd_q[6]) && strobe_rising == wd_q[0])
    else $error("audio clock controls do not follow the written value");
  audio_decode_a: assert property (wr_ok && reg_addr == 8'h28 |=>
    aux_i2s_en == wd_q[3] && gpio1_is_aux_ws == wd_q[3] && i2s_out_en == !wd_q[2])
    else $error("audio path controls do not follow the written value");
  frame_block_a: assert property (frame_transport |-> !surround_en)
    else $error("surround enabled with frame transport");
  unmapped_read_a: assert property (reg_addr > 8'h2b |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  master_low_a: assert property (master_start && !master_busy && !slave_data_ready &&
    powerdown_bar_pin |=> !master_scl_out [*4])
    else $error("clock low period did not start");
  scl_idle_a: assert property (!master_busy |-> master_scl_out)
    else $error("clock low while idle");
  release_pulse_a: assert property (slave_scl_release |=> !slave_scl_release)
    else $error("release longer than one cycle");
  pd_defaults_a: assert property (!powerdown_bar_pin |=> master_scl_out &&
    !slave_scl_release && i2s_out_en && audio_pll_on && !white_balance_en)
    else $error("power-down did not restore defaults");
  // ==========
  // Coverage
  cover property (wr_ok && reg_addr == 8'h29);
  cover property (slave_scl_release);
  cover property (master_start && !master_busy);
endmodule // davc_chk

bind davc_cfg_regs davc_chk i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .powerdown_bar_pin(powerdown_bar_pin),
  .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .frame_transport(frame_transport), .master_start(master_start),
  .slave_data_ready(slave_data_ready), .master_scl_out(master_scl_out),
  .master_busy(master_busy), .slave_scl_release(slave_scl_release),
  .surround_en(surround_en), .aux_i2s_en(aux_i2s_en), .gpio1_is_aux_ws(gpio1_is_aux_ws),
  .i2s_out_en(i2s_out_en), .audio_pll_on(audio_pll_on), .strobe_rising(strobe_rising),
  .sync_timing_mode(sync_timing_mode), .hs_active_low(hs_active_low),
  .vs_active_low(vs_active_low), .de_active_low(de_active_low),
  .dither_stage_two(dither_stage_two), .dither_stage_one(dither_stage_one),
  .high_dither_stage_two(high_dither_stage_two),
  .high_dither_stage_one(high_dither_stage_one), .white_balance_en(white_balance_en),
  .table_reload_en(table_reload_en), .table_page(table_page));

// File: tb/davc_host.sv
`timescale 1ns/1ps
// ==========
// Host side of the local register port
module davc_host (
  // Clock
  input  wire       clk_sys,
  // Register port
  output reg        reg_wr    = 1'b0,
  output reg  [7:0] reg_addr  = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  input  wire [7:0] reg_rdata
);
  // Released data is inverted so a stale byte is never taken for a live one
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys) reg_wr <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys) reg_wr <= 1'b0;
      reg_wdata <= ~v;
    end
  endtask
  // Read data trails the address by one cycle
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge clk_sys) reg_addr <= a;
      repeat (2) @(posedge clk_sys);
      v = reg_rdata;
    end
  endtask
endmodule // davc_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ==========
  // Stimulus and observed signals
  reg        clk_sys = 1'b0, rst_b = 1'b0, powerdown_bar_pin = 1'b1, fc_wr = 1'b0;
  reg  [7:0] fc_wdata = 8'h00;
  reg        selftest_run = 1'b0, selftest_err = 1'b0, repeater_mode = 1'b0;
  reg        inband_surround_vld = 1'b0, inband_surround = 1'b0, frame_transport = 1'b0;
  reg        master_start = 1'b0, slave_data_ready = 1'b0;
  wire       reg_wr, master_scl_out, master_busy, slave_scl_release, aux_i2s_en;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire       gpio1_is_aux_ws, gpio0_is_aux_data, i2s_out_en, surround_en, audio_pll_on;
  wire       strobe_rising, sync_timing_mode, hs_active_low, vs_active_low, de_active_low;
  wire       dither_stage_two, dither_stage_one, high_dither_stage_two, high_dither_stage_one;
  wire       white_balance_en, table_reload_en;
  wire [1:0] table_page;
  wire [7:0] dith = {sync_timing_mode, hs_active_low, vs_active_low, de_active_low,
                     dither_stage_two, dither_stage_one, high_dither_stage_two,
                     high_dither_stage_one};
  wire [7:0] aud  = {aux_i2s_en, gpio1_is_aux_ws, gpio0_is_aux_data, i2s_out_en,
                     surround_en, audio_pll_on, strobe_rising, 1'b0};
  wire [7:0] tbl  = {table_page, white_balance_en, table_reload_en, 4'h0};
  integer    fails = 0, compares = 0, cyc = 0, i, lo, hi;
  reg  [7:0] d;
  always #5 clk_sys = ~clk_sys;
  davc_host i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  davc_cfg_regs i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .powerdown_bar_pin(powerdown_bar_pin),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fc_wr(fc_wr), .fc_wdata(fc_wdata), .selftest_run(selftest_run),
    .selftest_err(selftest_err), .repeater_mode(repeater_mode),
    .inband_surround_vld(inband_surround_vld), .inband_surround(inband_surround),
    .frame_transport(frame_transport), .master_start(master_start),
    .master_scl_out(master_scl_out), .master_busy(master_busy),
    .slave_data_ready(slave_data_ready), .slave_scl_release(slave_scl_release),
    .aux_i2s_en(aux_i2s_en), .gpio1_is_aux_ws(gpio1_is_aux_ws),
    .gpio0_is_aux_data(gpio0_is_aux_data), .i2s_out_en(i2s_out_en),
    .surround_en(surround_en), .audio_pll_on(audio_pll_on), .strobe_rising(strobe_rising),
    .sync_timing_mode(sync_timing_mode), .hs_active_low(hs_active_low),
    .vs_active_low(vs_active_low), .de_active_low(de_active_low),
    .dither_stage_two(dither_stage_two), .dither_stage_one(dither_stage_one),
    .high_dither_stage_two(high_dither_stage_two),
    .high_dither_stage_one(high_dither_stage_one), .table_page(table_page),
    .white_balance_en(white_balance_en), .table_reload_en(table_reload_en));
  // ==========
  // Checking and closing
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] e);
    begin
      i_host.rd(a, d);
      chk("rdata", d, e);
    end
  endtask
  task stop_test;
    begin
      $display("Compares %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      stop_test;
    end
  end
  // ==========
  // Scenarios
  task t_defaults;
    begin
      rdchk(8'h25, 8'h00);
      rdchk(8'h26, 8'h83);
      rdchk(8'h27, 8'h84);
      for (i = 8'h28; i < 8'h2c; i = i + 1) rdchk(i[7:0], 8'h00);
      rdchk(8'h30, 8'h00);
      chk("dither", dith, 8'h03);
      chk("audio", aud, 8'h14);
      $display("defaults done");
    end
  endtask
  task t_masks;
    begin
      for (i = 8'h25; i < 8'h2c; i = i + 1) i_host.wr(i[7:0], 8'hff);
      rdchk(8'h25, 8'h00);
      rdchk(8'h26, 8'hff);
      rdchk(8'h27, 8'hff);
      rdchk(8'h28, 8'h8d);
      rdchk(8'h2a, 8'hf0);
      rdchk(8'h2b, 8'hc1);
      chk("dither", dith, 8'hfc);
      chk("audio", aud, 8'hea);
      for (i = 0; i < 4; i = i + 1) begin
        i_host.wr(8'h2a, {i[1:0], i[0], ~i[0], 4'h0});
        @(posedge clk_sys);
        chk("table", tbl, {i[1:0], i[0], ~i[0], 4'h0});
      end
      $display("masks done");
    end
  endtask
  task t_fc;
    begin
      i_host.wr(8'h28, 8'h00);
      @(posedge clk_sys) fc_wr <= 1'b1;
      fc_wdata <= 8'h01;
      @(posedge clk_sys) fc_wr <= 1'b0;
      rdchk(8'h28, 8'h01);
      chk("surround", {7'h0, surround_en}, 8'h01);
      frame_transport <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("surround", {7'h0, surround_en}, 8'h00);
      frame_transport <= 1'b0;
      i_host.wr(8'h28, 8'h80);
      @(posedge clk_sys) fc_wr <= 1'b1;
      fc_wdata <= 8'h0d;
      @(posedge clk_sys) fc_wr <= 1'b0;
      rdchk(8'h28, 8'h80);
      repeater_mode <= 1'b1;
      inband_surround <= 1'b1;
      inband_surround_vld <= 1'b1;
      @(posedge clk_sys) inband_surround_vld <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("surround", {7'h0, surround_en}, 8'h01);
      $display("forward channel done");
    end
  endtask
  task errs(input integer n);
    begin
      selftest_run <= 1'b1;
      @(posedge clk_sys) selftest_err <= (n > 0);
      repeat (n > 0 ? n : 1) @(posedge clk_sys);
      selftest_err <= 1'b0;
      selftest_run <= 1'b0;
    end
  endtask
  task t_tally;
    begin
      errs(3);
      rdchk(8'h25, 8'h03);
      powerdown_bar_pin <= 1'b0;
      @(posedge clk_sys) powerdown_bar_pin <= 1'b1;
      rdchk(8'h25, 8'h00);
      rdchk(8'h26, 8'h83);
      errs(300);
      rdchk(8'h25, 8'hff);
      errs(0);
      rdchk(8'h25, 8'h00);
      $display("tally done");
    end
  endtask
  task t_scl;
    begin
      i_host.wr(8'h27, 8'h02);
      i_host.wr(8'h26, 8'h03);
      @(posedge clk_sys) master_start <= 1'b1;
      @(posedge clk_sys) master_start <= 1'b0;
      lo = 0;
      hi = 0;
      repeat (60) begin
        @(posedge clk_sys) #1;
        if (master_scl_out === 1'b0) lo = lo + 1;
        else if (master_busy === 1'b1) hi = hi + 1;
      end
      chk("scl_low", {7'h0, lo >= 10 && lo <= 15}, 8'h01);
      chk("scl_high", {7'h0, hi >= 14 && hi <= 21}, 8'h01);
      @(posedge clk_sys) slave_data_ready <= 1'b1;
      @(posedge clk_sys) slave_data_ready <= 1'b0;
      lo = 0;
      hi = 0;
      repeat (30) begin
        @(posedge clk_sys) #1;
        lo = lo + 1;
        if (slave_scl_release === 1'b1 && hi == 0) hi = lo;
      end
      chk("release", {7'h0, hi >= 9 && hi <= 16}, 8'h01);
      $display("clock timing done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_defaults;
    t_masks;
    t_fc;
    t_tally;
    t_scl;
    stop_test;
  end
endmodule // tb_top
